/* lslc_consts.svh */
// constants for the lane status and latency control register bank
// assumes inclusion by bare name from each design file of the bank
//
// Behaviour
// - The alignment FIFO error bit goes high on a FIFO error and stays high until the status is read.
// - The align-sequence bit live-shows whether the aligner sends the sequence.
// - The signal-loss bit latches high on loss of signal on the selected lane.
// - The lane sync bit latches low, so any loss of sync on the selected lane shows until read.
// - The decode error bit latches high on an invalid word on the chosen lane.
// - Four per-lane counters count decode errors whatever lane is selected.
// - Start-select 0 starts timing on slow transmit, 1 on fast receive.
// - Stop-select 0 stops timing on slow receive, 1 on fast transmit.
// - The two-bit divider field divides the timing clock by 1, 2, 4 or 8.
// - The divider applies only while clock-select is 0 and is ignored at 1.
// - A larger divide ratio trades resolution for a longer range.
// - Latency measurement runs only while the enable bit is 1; reset is 0.
// - Channel-select 0 measures channel A and 1 measures channel B.
// - Clock-select 1 times the measurement with the channel byte clock.
// - The 20-bit latency counter saturates at its maximum value.
`ifndef LSLC_CONSTS_SVH
`define LSLC_CONSTS_SVH

// ****************************************************
// register indices (byte address is four times index)
// ****************************************************
`define LSLC_IDX_ERRCNT0 6'h11
`define LSLC_IDX_STATUS 6'h15
`define LSLC_IDX_CTRL 6'h16
`define LSLC_IDX_LANESEL 6'h1a
`define LSLC_IDX_MEAS_HI 6'h1b
`define LSLC_IDX_MEAS_LO 6'h1c

// ****************************************************
// reset values and masks
// ****************************************************
`define LSLC_ERRCNT_RESET 16'hfffd
`define LSLC_ERRCNT_MAX 16'hffff
`define LSLC_CTRL_RESET 16'h7f00
`define LSLC_CTRL_WMASK 16'hfff7
`define LSLC_LANESEL_RESET 2'h0
`define LSLC_COUNT_MAX 20'hfffff

// ****************************************************
// field positions
// ****************************************************
`define LSLC_ST_FIFO 15
`define LSLC_ST_SEQ 11
`define LSLC_ST_LOS 10
`define LSLC_ST_SYNC 8
`define LSLC_ST_DEC 3
`define LSLC_CT_START 7
`define LSLC_CT_STOP 6
`define LSLC_CT_DIV_HI 5
`define LSLC_CT_DIV_LO 4
`define LSLC_CT_CLKSEL 2
`define LSLC_CT_EN 1
`define LSLC_CT_CHAN 0
`define LSLC_MEAS_DONE 4

`endif

/* lslc_meas.sv */
// latency measurement engine: waits for start, counts ticks until stop
// assumes single-cycle start, stop and tick events on pclk
`timescale 1ns/1ps
`include "lslc_consts.svh"
module lslc_meas
  import lslc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // engine side of the measurement link
  lslc_meas_if.engine m
);

  lslc_state_e state;
  lslc_count_t cnt;

  // ****************************************************
  // state machine
  // ****************************************************
  // sequence idle, armed, counting, done
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= LSLC_IDLE;
    else if (!m.enable)
      state <= LSLC_IDLE;
    else
    begin
      case (state)
        LSLC_IDLE: state <= LSLC_ARMED;
        LSLC_ARMED: if (m.start_evt) state <= LSLC_COUNTING;
        LSLC_COUNTING: if (m.stop_evt) state <= LSLC_DONE;
        LSLC_DONE: if (m.clear) state <= LSLC_ARMED;
        default: state <= LSLC_IDLE;
      endcase
    end
  end

  // ****************************************************
  // cycle counter
  // ****************************************************
  // counts ticks, saturates, cleared on re-arm
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= '0;
    else if (state == LSLC_ARMED && m.start_evt)
      cnt <= '0;
    else if (state == LSLC_COUNTING && m.tick && cnt != `LSLC_COUNT_MAX)
      cnt <= cnt + 20'h00001;
    else if (state == LSLC_DONE && m.clear)
      cnt <= '0;
  end

  // result reads zero until the stop point is seen
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m.done <= 1'b0;
      m.count <= '0;
    end
    else
    begin
      m.done <= (state == LSLC_DONE) && !m.clear && m.enable;
      m.count <= ((state == LSLC_DONE) && !m.clear && m.enable) ? cnt : '0;
    end
  end

endmodule

/* lslc_meas_if.sv */
// link between register bank and latency measurement engine
// assumes both ends run on pclk
`timescale 1ns/1ps
interface lslc_meas_if;
  import lslc_pkg::*;
  logic enable;
  logic start_evt;
  logic stop_evt;
  logic tick;
  logic clear;
  logic done;
  lslc_count_t count;
  modport ctrl (output enable, start_evt, stop_evt, tick, clear,
    input done, count);
  modport engine (input enable, start_evt, stop_evt, tick, clear,
    output done, count);
endinterface

/* lslc_pkg.sv */
// types for the lane status and latency control register bank
// assumes nothing beyond a systemverilog compiler
package lslc_pkg;
  // measurement engine states, one-hot
  typedef enum logic [3:0]
  {
    LSLC_IDLE = 4'b0001,
    LSLC_ARMED = 4'b0010,
    LSLC_COUNTING = 4'b0100,
    LSLC_DONE = 4'b1000
  } lslc_state_e;
  typedef logic [1:0] lslc_lane_t;
  typedef logic [19:0] lslc_count_t;
endpackage

/* lslc_regs.sv */
// lane status and latency control register bank with apb slave
// assumes apb3 master on pclk; status and event inputs come from
// other clock domains and are synchronised here
`timescale 1ns/1ps
`include "lslc_consts.svh"
module lslc_regs
  import lslc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int LANES = 4,
  parameter int CHANS = 2
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // lane aligner status, asynchronous levels
  input wire logic align_fifo_error,
  input wire logic align_sequence_sending,
  input wire logic [LANES-1:0] slow_side_signal_loss,
  input wire logic [LANES-1:0] lane_sync_ok,
  input wire logic [LANES-1:0] lane_decode_error,
  // latency points per channel, asynchronous comma flags
  input wire logic [CHANS-1:0] ls_tx_comma,
  input wire logic [CHANS-1:0] hs_rx_comma,
  input wire logic [CHANS-1:0] ls_rx_comma,
  input wire logic [CHANS-1:0] hs_tx_comma,
  // recovered byte clocks per channel, sampled as data
  input wire logic [CHANS-1:0] recovered_byte_clk
);

  localparam int SW = 2 + 3 * LANES + 5 * CHANS;

  // ****************************************************
  // decoding functions
  // ****************************************************
  // true for any mapped register index
  function automatic logic reg_hit(input logic [5:0] idx);
    reg_hit = (idx >= `LSLC_IDX_ERRCNT0 && idx <= `LSLC_IDX_CTRL) ||
      (idx >= `LSLC_IDX_LANESEL && idx <= `LSLC_IDX_MEAS_LO);
  endfunction

  // low bits kept clear of the divider count for each ratio
  function automatic logic [2:0] div_mask(input logic [1:0] code);
    case (code)
      2'h0: div_mask = 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  endfunction

  // ****************************************************
  // input synchronisers
  // ****************************************************
  logic [SW-1:0] raw;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [SW-1:0] sync3;

  assign raw = {align_fifo_error, align_sequence_sending,
    slow_side_signal_loss, lane_sync_ok, lane_decode_error,
    ls_tx_comma, hs_rx_comma, ls_rx_comma, hs_tx_comma,
    recovered_byte_clk};

  // two flops per input, third flop only for edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end
    else
    begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // split the synchronised vector back into named groups
  logic fifo_err_s;
  logic seq_s;
  logic [LANES-1:0] los_s;
  logic [LANES-1:0] sync_s;
  logic [LANES-1:0] dec_s;
  logic [LANES-1:0] dec_rise;
  logic [CHANS-1:0] ls_tx_rise;
  logic [CHANS-1:0] hs_rx_rise;
  logic [CHANS-1:0] ls_rx_rise;
  logic [CHANS-1:0] hs_tx_rise;
  logic [CHANS-1:0] byte_rise;
  logic [SW-1:0] rise;

  assign rise = sync2 & ~sync3;
  assign fifo_err_s = sync2[SW-1];
  assign seq_s = sync2[SW-2];
  assign los_s = sync2[SW-3 -: LANES];
  assign sync_s = sync2[SW-3-LANES -: LANES];
  assign dec_s = sync2[SW-3-2*LANES -: LANES];
  assign dec_rise = rise[SW-3-2*LANES -: LANES];
  assign ls_tx_rise = rise[5*CHANS-1 -: CHANS];
  assign hs_rx_rise = rise[4*CHANS-1 -: CHANS];
  assign ls_rx_rise = rise[3*CHANS-1 -: CHANS];
  assign hs_tx_rise = rise[2*CHANS-1 -: CHANS];
  assign byte_rise = rise[CHANS-1:0];

  // ****************************************************
  // apb access decode
  // ****************************************************
  logic [5:0] idx;
  logic aligned;
  logic take;
  logic hit;
  logic wr_take;
  logic rd_take;

  // every side effect happens on the first access cycle, with pready low
  assign idx = paddr[7:2];
  // upper address bits beyond the index must be clear, for any width
  assign aligned = (paddr[1:0] == 2'h0) && ((paddr >> 8) == '0);
  assign take = psel && penable && !pready;
  assign hit = aligned && reg_hit(idx);
  assign wr_take = take && pwrite && hit;
  assign rd_take = take && !pwrite && hit;

  // ****************************************************
  // control registers
  // ****************************************************
  logic [15:0] ctrl;
  lslc_lane_t lane_sel;

  // latency control, bit 3 unused and read as zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= `LSLC_CTRL_RESET;
    else if (wr_take && idx == `LSLC_IDX_CTRL)
      ctrl <= pwdata[15:0] & `LSLC_CTRL_WMASK;
  end

  // lane shown in the status register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lane_sel <= `LSLC_LANESEL_RESET;
    else if (wr_take && idx == `LSLC_IDX_LANESEL)
      lane_sel <= pwdata[1:0];
  end

  // ****************************************************
  // latched status bits
  // ****************************************************
  logic st_clr;
  logic fifo_err_l;
  logic los_l;
  logic sync_l;
  logic dec_l;
  logic los_cur;
  logic sync_cur;
  logic dec_cur;

  assign st_clr = rd_take && idx == `LSLC_IDX_STATUS;
  assign los_cur = los_s[lane_sel];
  assign sync_cur = sync_s[lane_sel];
  assign dec_cur = dec_s[lane_sel];

  // latch high: new condition wins over a clearing read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fifo_err_l <= 1'b0;
      los_l <= 1'b0;
      dec_l <= 1'b0;
    end
    else
    begin
      fifo_err_l <= fifo_err_s | (fifo_err_l & ~st_clr);
      los_l <= los_cur | (los_l & ~st_clr);
      dec_l <= dec_cur | (dec_l & ~st_clr);
    end
  end

  // latch low: a drop stays visible until the register is read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_l <= 1'b0;
    else
      sync_l <= sync_cur & (sync_l | st_clr);
  end

  // ****************************************************
  // per-lane error counters
  // ****************************************************
  logic [15:0] err_cnt [LANES];

  // clear on read, an error in the same cycle counts as one
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_err
      logic clr;
      assign clr = rd_take && idx == `LSLC_IDX_ERRCNT0 + 6'(g);
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          err_cnt[g] <= `LSLC_ERRCNT_RESET;
        else if (clr)
          err_cnt[g] <= {15'h0000, dec_rise[g]};
        else if (dec_rise[g] && err_cnt[g] != `LSLC_ERRCNT_MAX)
          err_cnt[g] <= err_cnt[g] + 16'h0001;
      end
    end
  endgenerate

  // ****************************************************
  // measurement clock and point selection
  // ****************************************************
  logic [2:0] div_cnt;
  logic div_tick;
  logic chan;
  logic [1:0] div_code;

  assign chan = ctrl[`LSLC_CT_CHAN];
  assign div_code = ctrl[`LSLC_CT_DIV_HI:`LSLC_CT_DIV_LO];

  // free-running divider; wider ratio, coarser step, longer reach
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt <= 3'h0;
    else
      div_cnt <= div_cnt + 3'h1;
  end

  assign div_tick = (div_cnt & div_mask(div_code)) == 3'h0;

  lslc_meas_if mi ();

  assign mi.enable = ctrl[`LSLC_CT_EN];
  assign mi.start_evt = ctrl[`LSLC_CT_START] ? hs_rx_rise[chan] :
    ls_tx_rise[chan];
  assign mi.stop_evt = ctrl[`LSLC_CT_STOP] ? hs_tx_rise[chan] :
    ls_rx_rise[chan];
  // byte clock ignores the divider
  assign mi.tick = ctrl[`LSLC_CT_CLKSEL] ? byte_rise[chan] :
    div_tick;
  assign mi.clear = rd_take && idx == `LSLC_IDX_MEAS_LO;

  // measurement engine
  lslc_meas u_meas
  (
    .pclk(pclk),
    .presetn(presetn),
    .m(mi.engine)
  );

  // ****************************************************
  // read multiplexer
  // ****************************************************
  logic [15:0] rd_value;
  logic [15:0] status_word;

  // reserved status bits read zero
  always_comb
  begin
    status_word = 16'h0000;
    status_word[`LSLC_ST_FIFO] = fifo_err_l;
    status_word[`LSLC_ST_SEQ] = seq_s;
    status_word[`LSLC_ST_LOS] = los_l;
    status_word[`LSLC_ST_SYNC] = sync_l;
    status_word[`LSLC_ST_DEC] = dec_l;
  end

  // select the addressed word
  always_comb
  begin
    rd_value = 16'h0000;
    case (idx)
      `LSLC_IDX_STATUS: rd_value = status_word;
      `LSLC_IDX_CTRL: rd_value = ctrl;
      `LSLC_IDX_LANESEL: rd_value = {14'h0000, lane_sel};
      `LSLC_IDX_MEAS_HI: rd_value = {11'h000, mi.done, mi.count[19:16]};
      `LSLC_IDX_MEAS_LO: rd_value = mi.count[15:0];
      default:
      begin
        if (idx >= `LSLC_IDX_ERRCNT0 && idx < `LSLC_IDX_STATUS)
          rd_value = err_cnt[2'(idx - `LSLC_IDX_ERRCNT0)];
      end
    endcase
  end

  // ****************************************************
  // apb response
  // ****************************************************
  // one wait state: pready rises one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= take;
      pslverr <= take && !hit;
      if (take)
        prdata <= (pwrite || !hit) ? 32'h00000000 : {16'h0000, rd_value};
    end
  end

endmodule

/* lslc_regs_asserts.sv */
// checker for the lane status and latency control register bank
// assumes only the bank's own ports, sampled on pclk
`timescale 1ns/1ps
`include "lslc_consts.svh"
module lslc_regs_asserts
  import lslc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // aligner status
  input wire logic align_fifo_error,
  input wire logic align_sequence_sending
);
  logic acc_first;
  logic mapped;
  logic [5:0] idx;

  // first access cycle and decoded index
  assign acc_first = psel && penable && !pready;
  assign idx = paddr[7:2];
  assign mapped = (paddr[1:0] == 2'b00) &&
    ((idx >= 6'h11 && idx <= 6'h16) || (idx >= 6'h1a && idx <= 6'h1c));

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************************
  // sequences
  // ****************************************************
  sequence s_stat_rd;
    acc_first && !pwrite && idx == `LSLC_IDX_STATUS && paddr[1:0] == 2'b00;
  endsequence
  sequence s_fifo_on;
    align_fifo_error [*4] ##0 s_stat_rd;
  endsequence
  sequence s_seq_on;
    align_sequence_sending [*5] ##0 s_stat_rd;
  endsequence
  sequence s_seq_off;
    !align_sequence_sending [*5] ##0 s_stat_rd;
  endsequence

  // ****************************************************
  // properties
  // ****************************************************
  resp_next_a: assert property (acc_first |=> pready)
    else $error("answer not one cycle after access");
  resp_once_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  unmapped_err_a: assert property (acc_first && !mapped |=> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc_first && mapped |=> !pslverr)
    else $error("mapped access refused");
  ctrl_bit3_a: assert property (acc_first && !pwrite &&
    paddr == {`LSLC_IDX_CTRL, 2'b00} |=> !prdata[3])
    else $error("control bit 3 read as one");
  fifo_err_a: assert property (s_fifo_on |=> prdata[15])
    else $error("fifo error not reported");
  seq_live_a: assert property (s_seq_on |=> prdata[11])
    else $error("align sequence state not shown");
  seq_idle_a: assert property (s_seq_off |=> !prdata[11])
    else $error("align sequence state stuck high");
  result_zero_a: assert property (pready && !pwrite &&
    paddr == {`LSLC_IDX_MEAS_HI, 2'b00} && !prdata[4] |-> prdata[3:0] == 4'h0)
    else $error("result not zero before done");
endmodule

bind lslc_regs lslc_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .align_fifo_error(align_fifo_error),
  .align_sequence_sending(align_sequence_sending));

/* lslc_regs_bench.sv */
// self-checking bench for the lane status and latency control bank
// assumes the checker file is compiled alongside for the bind
`timescale 1ns/1ps
`include "lslc_consts.svh"
module lslc_regs_bench;
  import lslc_pkg::*;
  localparam int N = 64;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic align_fifo_error = 1'b0;
  logic align_sequence_sending = 1'b0;
  logic [3:0] slow_side_signal_loss = 4'h0;
  logic [3:0] lane_sync_ok = 4'hf;
  logic [3:0] lane_decode_error = 4'h0;
  logic [1:0] ls_tx_comma = 2'h0;
  logic [1:0] hs_rx_comma = 2'h0;
  logic [1:0] ls_rx_comma = 2'h0;
  logic [1:0] hs_tx_comma = 2'h0;
  logic [1:0] recovered_byte_clk = 2'h0;
  logic [31:0] rdv;
  logic erv;
  logic st, sp, ch, cs;
  logic [1:0] dv;
  logic [15:0] cv;
  logic [15:0] act [4] = '{16'h8100, 16'h0500, 16'h0108, 16'h0000};
  int ex;
  int mismatches = 0;
  int check_count = 0;

  lslc_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .align_fifo_error(align_fifo_error),
    .align_sequence_sending(align_sequence_sending),
    .slow_side_signal_loss(slow_side_signal_loss),
    .lane_sync_ok(lane_sync_ok), .lane_decode_error(lane_decode_error),
    .ls_tx_comma(ls_tx_comma), .hs_rx_comma(hs_rx_comma),
    .ls_rx_comma(ls_rx_comma), .hs_tx_comma(hs_tx_comma),
    .recovered_byte_clk(recovered_byte_clk));

  // clock and byte clock of eight pclk periods
  always #20 pclk = ~pclk;
  always
  begin
    repeat (4) @(posedge pclk);
    recovered_byte_clk <= ~recovered_byte_clk;
  end

  // ****************************************************
  // tasks
  // ****************************************************
  function automatic logic [7:0] ra(input logic [5:0] i);
    return {i, 2'b00};
  endfunction
  task automatic chk(input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("ERROR reg %h expected %h seen %h", a, e, g);
      mismatches++;
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [5:0] i, input logic [15:0] e);
    apb(1'b0, ra(i), 16'h0000);
    chk(ra(i), {16'h0000, e}, rdv);
  endtask
  // drive one status condition of a lane, then let it settle
  task automatic cond(input int k, input int ln, input logic v);
    case (k)
      0: align_fifo_error <= v;
      1: slow_side_signal_loss[ln] <= v;
      2: lane_decode_error[ln] <= v;
      default: lane_sync_ok[ln] <= ~v;
    endcase
    repeat (6) @(posedge pclk);
  endtask
  // drive a start or stop comma flag of one channel
  task automatic comma(input logic stop, input logic hs, input logic c,
    input logic v);
    case ({stop, hs})
      2'b00: ls_tx_comma[c] <= v;
      2'b01: hs_rx_comma[c] <= v;
      2'b10: ls_rx_comma[c] <= v;
      default: hs_tx_comma[c] <= v;
    endcase
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    finish_test();
  end

  // ****************************************************
  // tests
  // ****************************************************
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`LSLC_IDX_STATUS, 16'h0000);
    rd(`LSLC_IDX_STATUS, 16'h0100);
    rd(`LSLC_IDX_CTRL, 16'h7f00);
    for (int i = 0; i < 4; i++) rd(6'h11 + 6'(i), 16'hfffd);
    rd(`LSLC_IDX_LANESEL, 16'h0000);
    apb(1'b1, ra(`LSLC_IDX_CTRL), 16'hffff);
    rd(`LSLC_IDX_CTRL, 16'hfff7);
    align_sequence_sending <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(`LSLC_IDX_STATUS, 16'h0900);
    align_sequence_sending <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(`LSLC_IDX_STATUS, 16'h0100);
    // each latch on each selected lane: set, hold after release, clear
    for (int ln = 0; ln < 4; ln++)
    begin
      apb(1'b1, ra(`LSLC_IDX_LANESEL), 16'(ln));
      for (int k = 0; k < 4; k++)
      begin
        cond(k, ln, 1'b1);
        rd(`LSLC_IDX_STATUS, act[k]);
        cond(k, ln, 1'b0);
        rd(`LSLC_IDX_STATUS, act[k]);
        rd(`LSLC_IDX_STATUS, 16'h0100);
      end
    end
    lane_decode_error <= 4'hf;
    repeat (6) @(posedge pclk);
    lane_decode_error <= 4'h0;
    repeat (6) @(posedge pclk);
    rd(`LSLC_IDX_STATUS, 16'h0108);
    for (int i = 0; i < 4; i++) rd(6'h11 + 6'(i), 16'h0002);
    apb(1'b0, 8'h80, 16'h0000);
    chk(8'h80, 32'h0000_0001, {31'h0, erv});
    apb(1'b1, 8'h59, 16'h0000);
    chk(8'h59, 32'h0000_0001, {31'h0, erv});
    rd(`LSLC_IDX_CTRL, 16'hfff7);
    // measurements: every divider, both points, both channels, byte clock
    for (int i = 0; i < 5; i++)
    begin
      st = i[0];
      sp = i[1];
      ch = i[0] ^ i[1];
      cs = (i == 4);
      dv = cs ? 2'b01 : 2'(i);
      cv = {8'h7f, st, sp, dv, 1'b0, cs, 1'b0, ch};
      ex = cs ? N / 8 : N >> dv;
      apb(1'b1, ra(`LSLC_IDX_CTRL), cv);
      apb(1'b1, ra(`LSLC_IDX_CTRL), cv | 16'h0002);
      rd(`LSLC_IDX_MEAS_HI, 16'h0000);
      comma(1'b0, st, ch, 1'b1);
      repeat (3) @(posedge pclk);
      comma(1'b0, st, ch, 1'b0);
      repeat (N - 3) @(posedge pclk);
      comma(1'b1, sp, ch, 1'b1);
      repeat (3) @(posedge pclk);
      comma(1'b1, sp, ch, 1'b0);
      repeat (8) @(posedge pclk);
      rd(`LSLC_IDX_MEAS_HI, 16'h0010);
      apb(1'b0, ra(`LSLC_IDX_MEAS_LO), 16'h0000);
      check_count++;
      if ($isunknown(rdv) || rdv < ex - 2 || rdv > ex + 2)
      begin
        $display("ERROR count expected %0d seen %h", ex, rdv);
        mismatches++;
      end
      rd(`LSLC_IDX_MEAS_HI, 16'h0000);
    end
    // disabled engine ignores start and stop
    apb(1'b1, ra(`LSLC_IDX_CTRL), 16'h7f00);
    comma(1'b0, 1'b0, 1'b0, 1'b1);
    repeat (3) @(posedge pclk);
    comma(1'b1, 1'b0, 1'b0, 1'b1);
    repeat (3) @(posedge pclk);
    ls_tx_comma <= 2'h0;
    ls_rx_comma <= 2'h0;
    repeat (8) @(posedge pclk);
    rd(`LSLC_IDX_MEAS_HI, 16'h0000);
    finish_test();
  end
endmodule
